// ### hdl/serial_baud_rate_generator.sv
// Operation
// (RULE_01) Mode 2 rate is clock over 32, doubled by the double bit.
// (RULE_02) Modes 1 and 3 use timer 1 overflow unless timer 2 selected.
// (RULE_03) Timer 1 source: overflow rate over 32, doubled by double bit.
// (RULE_04) Timer 1 auto-reload: clock over 16x12x(256 minus reload byte).
// (RULE_05) Slow rates: timer 1 16-bit with interrupt, firmware reloads it.
// (RULE_06) Firmware disables timer 1 interrupt and programs its mode.
// (RULE_07) Timer 2 high byte rollover reloads both bytes from reload register.
// (RULE_08) Timer 2 source: overflow rate over 16.
// (RULE_09) Receive and transmit select bits each pick timer 2 or timer 1.
// (RULE_10) Either select bit puts timer 2 in baud generator mode.
// (RULE_11) Baud generator rollover does not set timer 2 overflow flag.
// (RULE_12) External pin fall sets external flag, no reload, in baud mode.
// (RULE_13) External enable makes external pin an extra interrupt source.
// (RULE_14) Firmware stops timer 2 before touching its count or reload.
// (RULE_15) Timer 2 works as timer or counter via its select bit.
// (RULE_16) Baud-mode timer 2 counts every clock: clock over 16x(65536-reload).
// (RULE_17) Running baud timer: no count access, reload read only.
// (RULE_18) Receiver and transmitter get separate ticks from their sources.
`timescale 1ns/1ps
`default_nettype none
module serial_baud_rate_generator
  import baud_pkg::*;
(
  input  wire logic                        CLK,
  input  wire logic                        RST,
  input  wire logic                        PSEL,
  input  wire logic                        PENABLE,
  input  wire logic                        PWRITE,
  input  wire logic [baud_pkg::ADDR_W-1:0] PADDR,
  input  wire logic [baud_pkg::DATA_W-1:0] PWDATA,
  output var  logic [baud_pkg::DATA_W-1:0] PRDATA,
  output var  logic                        PREADY,
  output var  logic                        PSLVERR,
  input  wire logic                        T1_COUNT_IN,
  input  wire logic                        T2_COUNT_IN,
  input  wire logic                        T2_EXT_IN,
  output var  logic                        RX_BAUD_TICK,
  output var  logic                        TX_BAUD_TICK,
  output var  logic                        IRQ
);
  import baud_pkg::*;

  // Same choice for both directions, so one helper keeps them in step
  function automatic logic pick_tick(input logic use_t2, input logic t1_tick, input logic t2_tick);
    pick_tick = use_t2 ? t2_tick : t1_tick;
  endfunction

  // Timer 2 counting itself lives in the small counter module;
  // this module only feeds it increments, reloads and writes.

  logic [CTRL_W-1:0]     ctrl;
  logic [15:0]           t1_count;
  logic [15:0]           t2_reload;
  logic [NUM_EVENTS-1:0] int_status;
  logic [NUM_EVENTS-1:0] int_enable;
  logic [2:0]            t1_pre;
  logic [2:0]            t2_pre;
  logic                  t1_in_d;
  logic                  t2_in_d;
  logic                  t2_ext_d;
  logic [4:0]            t1_div;
  logic [3:0]            t2_div;
  logic [4:0]            m2_div;

  timer2_if t2 ();

  timer2_counter u_timer2 (
    .CLK (CLK),
    .RST (RST),
    .t2  (t2.tmr)
  );


  // Control fields
  // Every field is a plain slice of one register, so firmware can
  // change mode, sources and run bits in a single write.
  wire ser_mode_e ser_mode = ser_mode_e'(ctrl[CTRL_SER_MODE_LSB +: 2]);
  wire t1_mode_e  t1_mode  = t1_mode_e'(ctrl[CTRL_T1_MODE_LSB +: 2]);
  wire baud_double  = ctrl[CTRL_BAUD_DOUBLE];
  wire rx_sel       = ctrl[CTRL_RX_SEL];
  wire tx_sel       = ctrl[CTRL_TX_SEL];
  wire t2_run       = ctrl[CTRL_T2_RUN];
  wire t2_cnt_sel   = ctrl[CTRL_T2_CNT_SEL];
  wire t2_ext_en    = ctrl[CTRL_T2_EXT_EN];
  wire t1_run       = ctrl[CTRL_T1_RUN];
  wire t1_cnt_sel   = ctrl[CTRL_T1_CNT_SEL];


  // APB decode
  // The slave always inserts one wait state; the access cycle that
  // sees no ready yet is the one that registers the answer.
  wire access   = PSEL & PENABLE;
  wire answer   = access & ~PREADY;
  wire done     = access & PREADY;
  wire sel_ctrl = (PADDR == ADDR_CTRL);
  wire sel_t1   = (PADDR == ADDR_T1_COUNT);
  wire sel_t2   = (PADDR == ADDR_T2_COUNT);
  wire sel_rld  = (PADDR == ADDR_T2_RELOAD);
  wire sel_sts  = (PADDR == ADDR_INT_STATUS);
  wire sel_ien  = (PADDR == ADDR_INT_ENABLE);
  wire sel_clr  = (PADDR == ADDR_INT_CLEAR);
  wire sel_st   = (PADDR == ADDR_STATE);
  wire mapped   = sel_ctrl | sel_t1 | sel_t2 | sel_rld | sel_sts | sel_ien | sel_clr | sel_st;
  wire wr       = done & PWRITE & ~PSLVERR;
  wire wr_ctrl  = wr & sel_ctrl;
  wire wr_t1    = wr & sel_t1;
  wire wr_rld   = wr & sel_rld;
  wire wr_ien   = wr & sel_ien;
  wire wr_clr   = wr & sel_clr;

  // (RULE_10) Baud generator mode
  wire baud_mode = rx_sel | tx_sel;
  wire async_mode = (ser_mode != SER_MODE0);
  wire mode2      = (ser_mode == SER_MODE2);


  // Read-only view of the decoded operating state
  wire [3:0] state_bits = {mode2, tx_sel, rx_sel, baud_mode};

  logic [DATA_W-1:0] rdata;
  always_comb begin
    rdata = '0;
    if (sel_ctrl) rdata[CTRL_W-1:0] = ctrl;
    if (sel_t1)   rdata[15:0] = t1_count;
    if (sel_t2)   rdata[15:0] = t2.count;
    if (sel_rld)  rdata[15:0] = t2_reload;
    if (sel_sts)  rdata[NUM_EVENTS-1:0] = int_status;
    if (sel_ien)  rdata[NUM_EVENTS-1:0] = int_enable;
    if (sel_st)   rdata[3:0] = state_bits;
  end

  // One wait state: the answer is registered so PRDATA comes from a flop
  always_ff @(posedge CLK) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= '0;
    end else begin
      PREADY  <= answer;
      PSLVERR <= answer & ~mapped;
      if (answer) begin
        PRDATA <= (PWRITE | ~mapped) ? '0 : rdata;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl       <= CTRL_RESET;
      t2_reload  <= COUNT_RESET;
      int_enable <= EVENT_RESET;
    end else begin
      if (wr_ctrl) ctrl <= PWDATA[CTRL_W-1:0];
      if (wr_rld)  t2_reload <= PWDATA[15:0];
      if (wr_ien)  int_enable <= PWDATA[NUM_EVENTS-1:0];
    end
  end

  // Pin edge detection; pins are taken as synchronous.
  // Delay flops reset low, so a pin idling low after reset
  // cannot look like a falling edge.
  always_ff @(posedge CLK) begin
    if (RST) begin
      t1_in_d  <= 1'b0;
      t2_in_d  <= 1'b0;
      t2_ext_d <= 1'b0;
    end else begin
      t1_in_d  <= T1_COUNT_IN;
      t2_in_d  <= T2_COUNT_IN;
      t2_ext_d <= T2_EXT_IN;
    end
  end

  wire t1_fall  = t1_in_d & ~T1_COUNT_IN;
  wire t2_fall  = t2_in_d & ~T2_COUNT_IN;
  wire ext_fall = t2_ext_d & ~T2_EXT_IN;


  // Prescalers give the timer rate of clock over six.
  // They restart while the timer is stopped, so the first count
  // after a run bit is set comes a full prescale period later.
  localparam logic [2:0] PRE_LAST = 3'(TIMER_PRESCALE - 1);
  wire t1_pre_tick = (t1_pre == PRE_LAST);
  wire t2_pre_tick = (t2_pre == PRE_LAST);

  always_ff @(posedge CLK) begin
    if (RST) begin
      t1_pre <= 3'h0;
      t2_pre <= 3'h0;
    end else begin
      t1_pre <= (~t1_run | t1_pre_tick) ? 3'h0 : t1_pre + 3'h1;
      t2_pre <= (~t2_run | t2_pre_tick) ? 3'h0 : t2_pre + 3'h1;
    end
  end


  // Timer 1
  // Counter mode counts pin falls; the pin must stay at each level
  // for at least one clock for an edge to be seen.
  wire t1_inc = t1_run & (t1_cnt_sel ? t1_fall : t1_pre_tick);

  wire [12:0] t1_c13  = {t1_count[15:8], t1_count[4:0]};
  wire [12:0] t1_n13  = t1_c13 + 13'h0001;
  wire        t1_lowf = (t1_count[7:0] == 8'hFF);

  logic [15:0] next_t1_count;
  logic        t1_ovf;
  always_comb begin
    next_t1_count = t1_count;
    t1_ovf        = 1'b0;
    if (t1_inc) begin
      case (t1_mode)
        T1_COUNT13: begin
          next_t1_count = {t1_n13[12:5], t1_count[7:5], t1_n13[4:0]};
          t1_ovf        = (t1_c13 == 13'h1FFF);
        end
        // (RULE_05) 16-bit slow mode
        T1_COUNT16: begin
          next_t1_count = t1_count + 16'h0001;
          t1_ovf        = (t1_count == 16'hFFFF);
        end
        // (RULE_04) 8-bit auto-reload
        T1_AUTO8: begin
          next_t1_count = {t1_count[15:8], t1_lowf ? t1_count[15:8] : t1_count[7:0] + 8'h01};
          t1_ovf        = t1_lowf;
        end
        T1_HALT: begin
          next_t1_count = t1_count;
          t1_ovf        = 1'b0;
        end
        default: begin
          next_t1_count = t1_count;
          t1_ovf        = 1'b0;
        end
      endcase
    end
  end

  // A firmware write wins over a count in the same cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      t1_count <= COUNT_RESET;
    end else begin
      t1_count <= wr_t1 ? PWDATA[15:0] : next_t1_count;
    end
  end


  // Timer 2 controls
  // Writes to count or reload while running may collide with a reload;
  // firmware is expected to stop the timer first, hardware does not block it.
  // (RULE_15) Timer or counter
  // (RULE_16) Every clock in baud mode, pin falls instead when counter select is set
  assign t2.inc = t2_run & (t2_cnt_sel ? t2_fall : (baud_mode | t2_pre_tick));

  wire ext_event = ext_fall & t2_ext_en;

  // (RULE_12) No pin reload in baud mode
  assign t2.ext_reload = ext_event & ~baud_mode;
  assign t2.wr_count   = wr & sel_t2;
  assign t2.wr_data    = PWDATA[15:0];
  assign t2.reload     = t2_reload;

  // Interrupt events
  logic [NUM_EVENTS-1:0] events;
  always_comb begin
    events            = '0;
    // (RULE_05) Overflow raises timer 1 event
    events[EV_T1_OVF] = t1_ovf;
    // (RULE_11) Baud rollover suppressed
    events[EV_T2_OVF] = t2.rollover & ~baud_mode;
    // (RULE_13) External pin interrupt
    events[EV_T2_EXT] = ext_event;
  end

  wire [NUM_EVENTS-1:0] clr_bits = wr_clr ? PWDATA[NUM_EVENTS-1:0] : '0;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_sticky
      // New event wins over a clear in the same cycle
      always_ff @(posedge CLK) begin
        if (RST) begin
          int_status[gi] <= 1'b0;
        end else begin
          int_status[gi] <= events[gi] | (int_status[gi] & ~clr_bits[gi]);
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(int_status & int_enable);
    end
  end


  // Baud dividers
  // A double-bit change can leave a divider above its new limit;
  // the compare is greater-or-equal so it wraps on the next event.
  // (RULE_03) Timer 1 divide by 32 or 16
  wire [4:0] t1_last = baud_double ? 5'(T1_BAUD_DIV / 2 - 1) : 5'(T1_BAUD_DIV - 1);
  wire       t1_hit  = (t1_div >= t1_last);
  wire       t1_baud = t1_ovf & t1_hit;

  // (RULE_08) Timer 2 divide by 16
  wire t2_baud = t2.rollover & (t2_div == 4'(T2_BAUD_DIV - 1));

  // (RULE_01) Mode 2 divide by 32 or 16
  wire [4:0] m2_last = baud_double ? 5'(MODE2_DIV / 2 - 1) : 5'(MODE2_DIV - 1);
  wire       m2_hit  = (m2_div >= m2_last);

  always_ff @(posedge CLK) begin
    if (RST) begin
      t1_div <= 5'h00;
      t2_div <= 4'h0;
      m2_div <= 5'h00;
    end else begin
      if (t1_ovf) t1_div <= t1_hit ? 5'h00 : t1_div + 5'h01;
      if (t2.rollover) t2_div <= t2_div + 4'h1;
      m2_div <= (~mode2 | m2_hit) ? 5'h00 : m2_div + 5'h01;
    end
  end

  // (RULE_09) Per-direction source select
  // (RULE_02) Timer 1 unless timer 2 chosen
  wire rx_src_tick = pick_tick(rx_sel, t1_baud, t2_baud);
  wire tx_src_tick = pick_tick(tx_sel, t1_baud, t2_baud);
  wire m2_tick     = mode2 & m2_hit;


  // (RULE_18) Separate receive and transmit ticks
  // Registered so the ticks leave the block straight from flops.
  always_ff @(posedge CLK) begin
    if (RST) begin
      RX_BAUD_TICK <= 1'b0;
      TX_BAUD_TICK <= 1'b0;
    end else begin
      RX_BAUD_TICK <= async_mode & (mode2 ? m2_tick : rx_src_tick);
      TX_BAUD_TICK <= async_mode & (mode2 ? m2_tick : tx_src_tick);
    end
  end

endmodule
`default_nettype wire

// ### hdl/baud_pkg.sv
package baud_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CTRL_W = 12;
  localparam int NUM_EVENTS = 3;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_T1_COUNT   = 8'h04;
  localparam logic [7:0] ADDR_T2_COUNT   = 8'h08;
  localparam logic [7:0] ADDR_T2_RELOAD  = 8'h0C;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h10;
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h14;
  localparam logic [7:0] ADDR_INT_CLEAR  = 8'h18;
  localparam logic [7:0] ADDR_STATE      = 8'h1C;

  // Control register field positions
  localparam int CTRL_SER_MODE_LSB = 0;
  localparam int CTRL_BAUD_DOUBLE  = 2;
  localparam int CTRL_RX_SEL       = 3;
  localparam int CTRL_TX_SEL       = 4;
  localparam int CTRL_T2_RUN       = 5;
  localparam int CTRL_T2_CNT_SEL   = 6;
  localparam int CTRL_T2_EXT_EN    = 7;
  localparam int CTRL_T1_RUN       = 8;
  localparam int CTRL_T1_CNT_SEL   = 9;
  localparam int CTRL_T1_MODE_LSB  = 10;

  // Interrupt status bit positions
  localparam int EV_T1_OVF = 0;
  localparam int EV_T2_OVF = 1;
  localparam int EV_T2_EXT = 2;

  // Reset values
  localparam logic [CTRL_W-1:0]     CTRL_RESET   = 12'h000;
  localparam logic [15:0]           COUNT_RESET  = 16'h0000;
  localparam logic [NUM_EVENTS-1:0] EVENT_RESET  = 3'h0;

  // Timing counts: prescale and mode 2 in clock cycles, baud dividers in timer overflows
  localparam int TIMER_PRESCALE = 6;
  localparam int T1_BAUD_DIV    = 32;
  localparam int T2_BAUD_DIV    = 16;
  localparam int MODE2_DIV      = 32;

  typedef enum logic [1:0] {
    SER_MODE0 = 2'b00,
    SER_MODE1 = 2'b01,
    SER_MODE2 = 2'b10,
    SER_MODE3 = 2'b11
  } ser_mode_e;

  typedef enum logic [1:0] {
    T1_COUNT13 = 2'b00,
    T1_COUNT16 = 2'b01,
    T1_AUTO8   = 2'b10,
    T1_HALT    = 2'b11
  } t1_mode_e;

endpackage

// ### hdl/timer2_if.sv
`timescale 1ns/1ps
`default_nettype none
interface timer2_if;
  logic        inc;
  logic        ext_reload;
  logic        wr_count;
  logic [15:0] wr_data;
  logic [15:0] reload;
  logic [15:0] count;
  logic        rollover;

  modport ctl (output inc, ext_reload, wr_count, wr_data, reload, input count, rollover);
  modport tmr (input inc, ext_reload, wr_count, wr_data, reload, output count, rollover);
endinterface
`default_nettype wire

// ### hdl/timer2_counter.sv
`timescale 1ns/1ps
`default_nettype none
module timer2_counter
  import baud_pkg::*;
(
  input  wire logic CLK,
  input  wire logic RST,
  timer2_if.tmr     t2
);

  logic [15:0] count;
  wire         at_top = (count == 16'hFFFF);

  assign t2.count    = count;
  assign t2.rollover = t2.inc & at_top;

  // (RULE_07) Rollover reloads count
  always_ff @(posedge CLK) begin
    if (RST) begin
      count <= COUNT_RESET;
    end else if (t2.wr_count) begin
      count <= t2.wr_data;
    end else if (t2.rollover | t2.ext_reload) begin
      count <= t2.reload;
    end else if (t2.inc) begin
      count <= count + 16'h0001;
    end
  end

endmodule
`default_nettype wire

// ### tb/baud_props.sv
`timescale 1ns/1ps
`default_nettype none
module baud_props (
  input wire logic                        CLK,
  input wire logic                        RST,
  input wire logic                        PSEL,
  input wire logic                        PENABLE,
  input wire logic                        PWRITE,
  input wire logic [baud_pkg::ADDR_W-1:0] PADDR,
  input wire logic [baud_pkg::DATA_W-1:0] PWDATA,
  input wire logic [baud_pkg::DATA_W-1:0] PRDATA,
  input wire logic                        PREADY,
  input wire logic                        PSLVERR,
  input wire logic                        RX_BAUD_TICK,
  input wire logic                        TX_BAUD_TICK,
  input wire logic                        IRQ
);
  import baud_pkg::*;
  logic [CTRL_W-1:0] ctrl;
  logic [2:0]        ien;
  logic [7:0]        age;
  logic [7:0]        gap;
  wire acc  = PSEL && PENABLE && !PREADY;
  wire wdon = PSEL && PENABLE && PWRITE && PREADY;
  wire unm  = PADDR > ADDR_STATE || PADDR[1:0] != 2'b00;
  wire cwr  = wdon && PADDR == ADDR_CTRL;
  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl <= '0;
      ien <= '0;
      age <= '0;
      gap <= '0;
    end else begin
      ctrl <= cwr ? PWDATA[CTRL_W-1:0] : ctrl;
      ien <= (wdon && PADDR == ADDR_INT_ENABLE) ? PWDATA[2:0] : ien;
      age <= cwr ? 8'h00 : (age == 8'hFF ? age : age + 8'h01);
      gap <= RX_BAUD_TICK ? 8'h01 : (gap == 8'hFF ? gap : gap + 8'h01);
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  pready_wait_a: assert property (acc |=> PREADY) else $error("no ready after access");
  pready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready longer than one cycle");
  slverr_map_a: assert property (acc |=> PSLVERR == unm) else $error("error flag wrong");
  unmapped_zero_a: assert property (acc && !PWRITE && (unm || PADDR == ADDR_INT_CLEAR) |=> PRDATA == 32'h0)
    else $error("read data not zero");
  ctrl_readback_a: assert property (acc && !PWRITE && PADDR == ADDR_CTRL |=> PRDATA == {20'h0, ctrl})
    else $error("control readback wrong");
  rx_pulse_a: assert property (RX_BAUD_TICK |=> !RX_BAUD_TICK) else $error("rx tick too long");
  tx_pulse_a: assert property (TX_BAUD_TICK |=> !TX_BAUD_TICK) else $error("tx tick too long");
  mode0_silent_a: assert property (ctrl[1:0] == 2'b00 && $past(ctrl[1:0], 3) == 2'b00 && $past(ctrl[1:0]) == 2'b00
    |-> !RX_BAUD_TICK && !TX_BAUD_TICK) else $error("tick in mode zero");
  mode2_gap_a: assert property (RX_BAUD_TICK && ctrl[1:0] == 2'b10 && age > 8'd70
    |-> gap == (ctrl[CTRL_BAUD_DOUBLE] ? 8'd16 : 8'd32)) else $error("mode two period wrong");
  irq_masked_a: assert property (ien == 3'h0 && $past(ien) == 3'h0 |-> !IRQ) else $error("masked irq high");
  cover property (PREADY && PSLVERR);
  cover property (IRQ);
  cover property (RX_BAUD_TICK && ctrl[CTRL_RX_SEL] && !ctrl[CTRL_TX_SEL]);
endmodule
bind serial_baud_rate_generator baud_props chk (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .RX_BAUD_TICK(RX_BAUD_TICK), .TX_BAUD_TICK(TX_BAUD_TICK), .IRQ(IRQ));
`default_nettype wire

// ### tb/baud_tick_sink.sv
`timescale 1ns/1ps
`default_nettype none
module baud_tick_sink (
  input  wire logic CLK,
  input  wire logic RST,
  input  wire logic TICK,
  output var  int   period,
  output var  int   count
);
  int gap;
  always_ff @(posedge CLK) begin
    if (RST) begin
      gap <= 0;
      count <= 0;
      period <= 0;
    end else begin
      gap <= TICK ? 1 : gap + 1;
      if (TICK) begin
        period <= gap;
        count <= count + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import baud_pkg::*;
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, t1c = 0, t2c = 0, ext = 1, tog = 0, etog = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd_v;
  logic        pready, pslverr, rxt, txt, irq, err_v;
  int          n_errors = 0, cmp_count = 0, seed = 32'h60ed, rxp, rxn, txp, txn, r1, r2, m, d, rx, tx;
  serial_baud_rate_generator dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .T1_COUNT_IN(t1c), .T2_COUNT_IN(t2c),
    .T2_EXT_IN(ext), .RX_BAUD_TICK(rxt), .TX_BAUD_TICK(txt), .IRQ(irq));
  baud_tick_sink rx_sink (.CLK(clk), .RST(rst), .TICK(rxt), .period(rxp), .count(rxn));
  baud_tick_sink tx_sink (.CLK(clk), .RST(rst), .TICK(txt), .period(txp), .count(txn));
  initial forever #2.5 clk = ~clk;
  // Toggling gives a falling edge every second clock
  always @(posedge clk) begin
    t1c <= 1'($random(seed));
    t2c <= tog ? ~t2c : 1'($random(seed));
    ext <= etog ? ~ext : 1'b1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    pen <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      $display("wrong value at %0t: no ready", $time);
    end
    rd_v = prdata;
    err_v = pslverr;
    psel <= 0;
    pen <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1, a, v);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic e);
    apb(0, a, 0);
    chk(rd_v, exp);
    chk(err_v, e);
  endtask
  function automatic int per(int md, int db, int sel, int cnt, int t1r, int t2r);
    if (md == 2) return db ? MODE2_DIV / 2 : MODE2_DIV;
    if (sel != 0) return T2_BAUD_DIV * (65536 - t2r) * (cnt ? 2 : 1);
    return TIMER_PRESCALE * (256 - t1r) * (db ? T1_BAUD_DIV / 2 : T1_BAUD_DIV);
  endfunction
  function automatic logic [31:0] cw(int md, int db, int s1, int s2, int c2, int x2, int t1);
    return 32'(md + (db << CTRL_BAUD_DOUBLE) + (s1 << CTRL_RX_SEL) + (s2 << CTRL_TX_SEL) + (1 << CTRL_T2_RUN)
      + (c2 << CTRL_T2_CNT_SEL) + (x2 << CTRL_T2_EXT_EN) + (t1 << CTRL_T1_RUN)
      + ((t1 ? int'(T1_AUTO8) : 0) << CTRL_T1_MODE_LSB));
  endfunction
  // Early intervals may straddle the reconfiguration, so the third one counts
  task automatic measure(input int erx, input int etx);
    int a, b, n;
    a = rxn;
    b = txn;
    n = 0;
    while ((rxn < a + 3 || txn < b + 3) && n < 4000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 4000) begin
      n_errors++;
      $display("wrong value at %0t: ticks missing", $time);
    end
    chk(rxp, erx);
    chk(txp, etx);
  endtask
  task final_report;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    final_report;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    rd(ADDR_CTRL, 0, 0);
    rd(ADDR_INT_STATUS, 0, 0);
    rd(ADDR_INT_CLEAR, 0, 0);
    rd(8'h24, 0, 1);
    rd(8'h02, 0, 1);
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_CTRL, cw(2, i, 0, 0, 0, 0, 0));
      measure(per(2, i, 0, 0, 0, 0), per(2, i, 0, 0, 0, 0));
    end
    for (int i = 0; i < 4; i++) begin
      r1 = 252 + ($random(seed) & 3);
      r2 = 65520 + ($random(seed) & 15);
      d = i % 2;
      m = 1 + 2 * d;
      rx = (i == 0 || i == 2);
      tx = (i == 1 || i == 2);
      wr(ADDR_CTRL, 0);
      wr(ADDR_T1_COUNT, (r1 << 8) | r1);
      wr(ADDR_T2_RELOAD, r2);
      wr(ADDR_T2_COUNT, r2);
      wr(ADDR_INT_ENABLE, 0);
      wr(ADDR_CTRL, cw(m, d, rx, tx, 0, 0, 1));
      rd(ADDR_T2_RELOAD, r2, 0);
      measure(per(m, d, rx, 0, r1, r2), per(m, d, tx, 0, r1, r2));
      rd(ADDR_STATE, (rx | tx) + 2 * rx + 4 * tx, 0);
    end
    wr(ADDR_CTRL, 0);
    wr(ADDR_T2_RELOAD, 32'h0000FFFF);
    wr(ADDR_T2_COUNT, 32'h0000FFFF);
    tog <= 1;
    wr(ADDR_CTRL, cw(1, 0, 1, 1, 1, 0, 0));
    measure(per(1, 0, 1, 1, 0, 65535), per(1, 0, 1, 1, 0, 65535));
    tog <= 0;
    wr(ADDR_CTRL, 0);
    wr(ADDR_INT_CLEAR, 7);
    wr(ADDR_T2_RELOAD, 32'h0000FFF0);
    wr(ADDR_T2_COUNT, 32'h0000FFF0);
    wr(ADDR_INT_ENABLE, 4);
    etog <= 1;
    wr(ADDR_CTRL, cw(1, 0, 1, 1, 0, 1, 0));
    measure(per(1, 0, 1, 0, 0, 65520), per(1, 0, 1, 0, 0, 65520));
    etog <= 0;
    rd(ADDR_INT_STATUS, 32'h4, 0);
    chk(irq, 1);
    wr(ADDR_INT_ENABLE, 0);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    wr(ADDR_INT_ENABLE, 4);
    wr(ADDR_INT_CLEAR, 4);
    rd(ADDR_INT_STATUS, 0, 0);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    final_report;
  end
endmodule
`default_nettype wire
